// file: src/swc_pkg.sv
// Constants, types and register map of the sleep and wake controller.
package swc_pkg;

  localparam int unsigned CLK_MHZ            = 125;
  localparam int unsigned OST_TIME_NS        = 16384;
  localparam int unsigned PLL_LOCK_TIME_NS   = 32000;
  localparam int unsigned REG_SWITCH_TIME_NS = 20000;
  localparam int unsigned OST_CYC  = (OST_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PLL_CYC  = (PLL_LOCK_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned REG_CYC  =
    (REG_SWITCH_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned TMR_W    = 16;

  localparam logic [7:0] ADDR_RESET_CONTROL_REG4  = 8'h00;
  localparam logic [7:0] ADDR_RESET_CONTROL_REG2  = 8'h04;
  localparam logic [7:0] ADDR_STAT   = 8'h08;
  localparam logic [7:0] ADDR_MASK   = 8'h0C;
  localparam logic [7:0] ADDR_STATE  = 8'h10;
  localparam logic [7:0] ADDR_CLKCFG = 8'h14;

  localparam int unsigned RET_SW_BIT    = 4;
  localparam int unsigned WDT_WAKE_BIT  = 5;
  localparam int unsigned TWO_SPEED_BIT = 0;
  localparam int unsigned EV_W          = 4;
  localparam int unsigned EV_SLEEP      = 0;
  localparam int unsigned EV_IRQ        = 1;
  localparam int unsigned EV_WDT        = 2;
  localparam int unsigned EV_RST        = 3;
  localparam int unsigned SYNC_W        = 3;
  localparam int unsigned SY_RST        = 0;
  localparam int unsigned SY_WDT        = 1;
  localparam int unsigned SY_SOSC       = 2;

  typedef enum logic [1:0] {
    SRC_FRC, SRC_XTAL, SRC_XTAL_PLL, SRC_SOSC
  } swc_clk_src_e;

  typedef enum logic [1:0] {
    ACT_NEXT, ACT_VECTOR, ACT_RESET
  } swc_wake_act_e;

  typedef enum logic [1:0] {
    ST_RUN, ST_SLEEP, ST_REG_UP, ST_OSC_WAIT
  } swc_state_e;

endpackage : swc_pkg

// file: src/swc_tmr_if.sv
// Link between the sequencer and its start-up delay timer.
`timescale 1ns/1ns
interface swc_tmr_if;
  logic                        load;
  logic [swc_pkg::TMR_W-1:0]   count;
  logic                        done;
  modport ctrl (output load, output count, input done);
  modport tmr  (input load, input count, output done);
endinterface : swc_tmr_if

// file: src/swc_sync.sv
// Two-stage synchroniser for inputs from outside the clock domain.
`timescale 1ns/1ns
module swc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         CLK,
  input  wire logic         RST_N,
  input  wire logic         CE,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge CLK) begin
      if (!RST_N) begin
        meta_q[i] <= 1'b0;
        q[i]      <= 1'b0;
      end else if (CE) begin
        meta_q[i] <= d[i];
        q[i]      <= meta_q[i];
      end
    end
  end

endmodule : swc_sync

// file: src/swc_startup_timer.sv
// Down counter that times oscillator start-up and regulator switch-over.
`timescale 1ns/1ns
module swc_startup_timer
  import swc_pkg::*;
(
  input  wire logic CLK,
  input  wire logic RST_N,
  input  wire logic CE,
  swc_tmr_if.tmr    tif
);

  logic [TMR_W-1:0] cnt_q;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cnt_q <= '0;
    end else if (CE) begin
      if (tif.load) begin
        cnt_q <= tif.count;
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  assign tif.done = (cnt_q == '0) && !tif.load;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N || !CE);

  property p_tmr_dec;
    (!tif.load && cnt_q != '0) |=> cnt_q == $past(cnt_q) - 1'b1;
  endproperty
  a_tmr_dec: assert property (p_tmr_dec)
    else $error("start-up timer did not count down");

endmodule : swc_startup_timer

// file: src/swc_sleep_wake_controller.sv
// Sleep and retention sleep entry, wake-up and clock restart sequencer.
//
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module swc_sleep_wake_controller #(
  parameter int unsigned IRQ_N   = 8,
  parameter int unsigned OST_N   = swc_pkg::OST_CYC,
  parameter int unsigned PLL_N   = swc_pkg::PLL_CYC,
  parameter int unsigned REG_N   = swc_pkg::REG_CYC
) (
  input  wire logic                   CLK,
  input  wire logic                   RST_N,
  input  wire logic                   CE,
  input  wire logic                   HSEL,
  input  wire logic [31:0]            HADDR,
  input  wire logic [1:0]             HTRANS,
  input  wire logic                   HWRITE,
  input  wire logic [2:0]             HSIZE,
  input  wire logic [31:0]            HWDATA,
  input  wire logic                   HREADY,
  output logic                        HREADYOUT,
  output logic                        HRESP,
  output logic      [31:0]            HRDATA,
  input  wire logic                   SLEEP_REQ,
  input  wire logic                   CFG_RETENTION_CONFIG_BIT,
  input  wire logic                   DEEP_SLEEP_EN,
  input  wire swc_pkg::swc_clk_src_e  OSC_SEL,
  input  wire logic [IRQ_N-1:0]       IRQ_FLAGS,
  input  wire logic [IRQ_N-1:0]       IRQ_ENABLE,
  input  wire logic                   GLOBAL_IRQ_EN,
  input  wire logic                   RESET_REQ,
  input  wire logic                   WDT_EXPIRE,
  input  wire logic                   SOSC_RUNNING,
  output logic                        CORE_CLK_EN,
  output logic                        MAIN_REG_EN,
  output logic                        RET_REG_EN,
  output logic                        RAM_RETAIN,
  output swc_pkg::swc_clk_src_e       CLK_SRC_SEL,
  output logic                        WAKE,
  output swc_pkg::swc_wake_act_e      WAKE_ACTION,
  output logic                        IRQ
);
  import swc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised pins and wake sources.

  logic [SYNC_W-1:0] sync_q;
  logic              wdt_prev_q;
  logic              rst_wake;
  logic              wdt_wake;
  logic              irq_wake;
  logic              wake_any;

  swc_sync #(.W(SYNC_W)) u_sync (
    .CLK   (CLK),
    .RST_N (RST_N),
    .CE    (CE),
    .d     ({SOSC_RUNNING, WDT_EXPIRE, RESET_REQ}),
    .q     (sync_q)
  );

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wdt_prev_q <= 1'b0;
    end else if (CE) begin
      wdt_prev_q <= sync_q[SY_WDT];
    end
  end

  assign rst_wake = sync_q[SY_RST];
  assign wdt_wake = sync_q[SY_WDT] && !wdt_prev_q;
  assign irq_wake = |(IRQ_FLAGS & IRQ_ENABLE);
  assign wake_any = rst_wake || wdt_wake || irq_wake;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer.

  swc_tmr_if tmr ();

  swc_startup_timer u_tmr (
    .CLK   (CLK),
    .RST_N (RST_N),
    .CE    (CE),
    .tif   (tmr.tmr)
  );

  swc_state_e       state_q;
  swc_state_e       state_d;
  swc_clk_src_e     held_src_q;
  swc_wake_act_e    act_q;
  logic             ret_q;
  logic             sw_ret_q;
  logic             two_speed_q;
  logic             wdt_flag_q;
  logic [TMR_W-1:0] osc_dly;
  logic [EV_W-1:0]  ev;

  always_comb begin
    osc_dly = '0;
    unique case (held_src_q)
      SRC_FRC:      osc_dly = '0;
      SRC_XTAL:     osc_dly = TMR_W'(OST_N);
      SRC_XTAL_PLL: osc_dly = TMR_W'(OST_N + PLL_N);
      SRC_SOSC:     osc_dly = sync_q[SY_SOSC] ? '0 : TMR_W'(OST_N);
    endcase
  end

  always_comb begin
    state_d   = state_q;
    tmr.load  = 1'b0;
    tmr.count = osc_dly;
    unique case (state_q)
      ST_RUN: begin
        if (SLEEP_REQ) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_any && ret_q) begin
          state_d   = ST_REG_UP;
          tmr.load  = 1'b1;
          tmr.count = TMR_W'(REG_N);
        end else if (wake_any && osc_dly == '0) begin
          state_d = ST_RUN;
        end else if (wake_any) begin
          state_d  = ST_OSC_WAIT;
          tmr.load = 1'b1;
        end
      end
      ST_REG_UP: begin
        if (tmr.done && osc_dly == '0) begin
          state_d = ST_RUN;
        end else if (tmr.done) begin
          state_d  = ST_OSC_WAIT;
          tmr.load = 1'b1;
        end
      end
      ST_OSC_WAIT: begin
        if (tmr.done) begin
          state_d = ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_q <= ST_RUN;
    end else if (CE) begin
      state_q <= state_d;
    end
  end

  // Retention select and source capture at sleep entry.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ret_q      <= 1'b0;
      held_src_q <= SRC_FRC;
    end else if (CE && state_q == ST_RUN && SLEEP_REQ) begin
      ret_q      <= !CFG_RETENTION_CONFIG_BIT && sw_ret_q;
      held_src_q <= OSC_SEL;
    end
  end

  // Wake action priority reset, watchdog, interrupt.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      act_q <= ACT_NEXT;
    end else if (CE && state_q == ST_SLEEP && wake_any) begin
      if (rst_wake) begin
        act_q <= ACT_RESET;
      end else if (wdt_wake) begin
        act_q <= ACT_NEXT;
      end else begin
        // Resume after sleep when global enable clear.
        act_q <= GLOBAL_IRQ_EN ? ACT_VECTOR : ACT_NEXT;
      end
    end
  end

  always_comb begin
    ev          = '0;
    ev[EV_SLEEP] = state_q == ST_RUN && SLEEP_REQ;
    ev[EV_RST]  = state_q == ST_SLEEP && rst_wake;
    ev[EV_WDT]  = state_q == ST_SLEEP && wdt_wake && !rst_wake;
    ev[EV_IRQ]  = state_q == ST_SLEEP && irq_wake && !rst_wake && !wdt_wake;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock, regulator and wake outputs.

  logic core_en_d;

  // Fast RC clocks core during two-speed wait.
  assign core_en_d = state_q == ST_RUN ||
                     (state_q == ST_OSC_WAIT && two_speed_q);

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      CORE_CLK_EN <= 1'b1;
      MAIN_REG_EN <= 1'b1;
      RET_REG_EN  <= 1'b0;
      RAM_RETAIN  <= 1'b0;
      CLK_SRC_SEL <= SRC_FRC;
      WAKE        <= 1'b0;
      WAKE_ACTION <= ACT_NEXT;
    end else if (CE) begin
      CORE_CLK_EN <= core_en_d;
      MAIN_REG_EN <= !(ret_q && state_q == ST_SLEEP);
      RET_REG_EN  <= ret_q && (state_q == ST_SLEEP || state_q == ST_REG_UP);
      // Data RAM kept by retention regulator.
      RAM_RETAIN  <= ret_q && state_q != ST_RUN;
      if (state_q == ST_RUN) begin
        CLK_SRC_SEL <= OSC_SEL;
      end else if (state_q == ST_OSC_WAIT && two_speed_q) begin
        CLK_SRC_SEL <= SRC_FRC;
      end else begin
        CLK_SRC_SEL <= held_src_q;
      end
      WAKE        <= core_en_d && !CORE_CLK_EN;
      WAKE_ACTION <= act_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite register slave.

  logic        addr_ok;
  logic        wr_q;
  logic [7:0]  waddr_q;
  logic [EV_W-1:0] stat_q;
  logic [EV_W-1:0] mask_q;
  logic        rd_clr;
  logic [31:0] rd_d;

  assign addr_ok   = HSEL && HREADY && HTRANS[1] && CE;
  assign rd_clr    = addr_ok && !HWRITE && HADDR[7:0] == ADDR_STAT;
  assign HREADYOUT = CE;
  assign HRESP     = 1'b0;
  assign IRQ       = |(stat_q & mask_q);

  always_comb begin
    rd_d = '0;
    unique case (HADDR[7:0])
      ADDR_RESET_CONTROL_REG4:  rd_d[RET_SW_BIT]    = sw_ret_q;
      ADDR_RESET_CONTROL_REG2:  rd_d[WDT_WAKE_BIT]  = wdt_flag_q;
      ADDR_STAT:   rd_d[EV_W-1:0]      = stat_q;
      ADDR_MASK:   rd_d[EV_W-1:0]      = mask_q;
      ADDR_STATE:  rd_d[4:0]           = {ret_q, held_src_q, state_q};
      ADDR_CLKCFG: rd_d[TWO_SPEED_BIT] = two_speed_q;
      default:     rd_d = '0;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wr_q    <= 1'b0;
      waddr_q <= '0;
      HRDATA  <= '0;
    end else if (CE) begin
      wr_q    <= addr_ok && HWRITE;
      waddr_q <= HADDR[7:0];
      if (addr_ok && !HWRITE) begin
        HRDATA <= rd_d;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sw_ret_q    <= 1'b0;
      two_speed_q <= 1'b0;
      mask_q      <= '0;
    end else if (CE && wr_q) begin
      if (waddr_q == ADDR_RESET_CONTROL_REG4) begin
        sw_ret_q <= HWDATA[RET_SW_BIT];
      end
      if (waddr_q == ADDR_CLKCFG) begin
        two_speed_q <= HWDATA[TWO_SPEED_BIT];
      end
      if (waddr_q == ADDR_MASK) begin
        mask_q <= HWDATA[EV_W-1:0];
      end
    end
  end

  // Watchdog wake flag, set wins over a clearing write.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wdt_flag_q <= 1'b0;
    end else if (CE) begin
      if (ev[EV_WDT]) begin
        wdt_flag_q <= 1'b1;
      end else if (wr_q && waddr_q == ADDR_RESET_CONTROL_REG2 && !HWDATA[WDT_WAKE_BIT]) begin
        wdt_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      stat_q <= '0;
    end else if (CE) begin
      stat_q <= (stat_q & ~{EV_W{rd_clr}}) | ev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N || !CE);

  property p_ret_regs;
    (state_q == ST_SLEEP && ret_q) |=> !MAIN_REG_EN && RET_REG_EN;
  endproperty
  a_ret_regs: assert property (p_ret_regs)
    else $error("regulators not swapped in retention sleep");

  property p_ret_longer;
    (state_q == ST_SLEEP && ret_q && wake_any) |=> state_q == ST_REG_UP;
  endproperty
  a_ret_longer: assert property (p_ret_longer)
    else $error("retention wake skipped regulator delay");

  property p_ret_sel;
    (state_q == ST_RUN && SLEEP_REQ) |=>
      ret_q == (!$past(CFG_RETENTION_CONFIG_BIT) && $past(sw_ret_q));
  endproperty
  a_ret_sel: assert property (p_ret_sel)
    else $error("retention selection wrong");

  property p_same_src;
    (state_q == ST_RUN && SLEEP_REQ) |=> held_src_q == $past(OSC_SEL);
  endproperty
  a_same_src: assert property (p_same_src)
    else $error("held clock source differs from entry source");

  property p_hold_clk;
    (state_q == ST_OSC_WAIT && !two_speed_q) |=> !CORE_CLK_EN;
  endproperty
  a_hold_clk: assert property (p_hold_clk)
    else $error("clock released before start-up delay");

  property p_sosc_fast;
    (state_q == ST_SLEEP && wake_any && !ret_q &&
     held_src_q == SRC_SOSC && sync_q[SY_SOSC]) |=> state_q == ST_RUN;
  endproperty
  a_sosc_fast: assert property (p_sosc_fast)
    else $error("delay applied to running secondary oscillator");

  property p_two_speed;
    (state_q == ST_OSC_WAIT && two_speed_q) |=>
      CORE_CLK_EN && CLK_SRC_SEL == SRC_FRC;
  endproperty
  a_two_speed: assert property (p_two_speed)
    else $error("two-speed start-up not on fast RC");

  property p_irq_wake;
    (state_q == ST_SLEEP && irq_wake) |=> state_q != ST_SLEEP;
  endproperty
  a_irq_wake: assert property (p_irq_wake)
    else $error("enabled interrupt did not wake");

  property p_vector;
    ev[EV_IRQ] |=> act_q == ($past(GLOBAL_IRQ_EN) ? ACT_VECTOR : ACT_NEXT);
  endproperty
  a_vector: assert property (p_vector)
    else $error("interrupt wake action wrong");

  property p_rst_wake;
    ev[EV_RST] |=> act_q == ACT_RESET ##0 state_q != ST_SLEEP;
  endproperty
  a_rst_wake: assert property (p_rst_wake)
    else $error("reset source did not wake");

  property p_wdt_wake;
    ev[EV_WDT] |=> wdt_flag_q && act_q == ACT_NEXT;
  endproperty
  a_wdt_wake: assert property (p_wdt_wake)
    else $error("watchdog wake flag or action wrong");

  property p_sleep_gate;
    state_q == ST_SLEEP |=> !CORE_CLK_EN;
  endproperty
  a_sleep_gate: assert property (p_sleep_gate)
    else $error("core clock running in sleep");

endmodule : swc_sleep_wake_controller

// file: sim/swc_core_model.sv
// Processor core model: issues sleep requests and records wake-ups.
`timescale 1ns/1ns
module swc_core_model (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   go,
  input  wire logic                   wake,
  input  wire swc_pkg::swc_wake_act_e wake_act,
  output logic                        sleep_req,
  output swc_pkg::swc_wake_act_e      last_act
);
  import swc_pkg::*;

  logic go_q;

  ////////////////////////////////////////////////////////////////////////////
  // One sleep instruction per rising go, one cycle long.
  always_ff @(posedge clk) begin
    go_q      <= rst_n & go;
    sleep_req <= rst_n & go & ~go_q;
  end

  // The core resumes as the wake action tells it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      last_act <= ACT_NEXT;
    end else if (wake) begin
      last_act <= wake_act;
    end
  end
endmodule : swc_core_model

// file: sim/swc_sleep_wake_controller_bench.sv
// Self-checking bench of the sleep and wake controller.
`timescale 1ns/1ns
module swc_sleep_wake_controller_bench;
  import swc_pkg::*;

  localparam int OSCILLATOR_STARTUP_TIMER = 4;
  localparam int PLL = 6;
  localparam int REG = 5;

  logic          clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic          cfg_retention_config_bit = 1'b0, deep_sleep_en = 1'b0, go = 1'b0;
  logic          global_irq_en = 1'b0, reset_req = 1'b0;
  logic          wdt_expire = 1'b0, sosc_running = 1'b0;
  logic          hreadyout, hresp, sleep_req, wake, irq;
  logic          core_clk_en, main_reg_en, ret_reg_en, ram_retain;
  logic [31:0]   haddr = '0, hwdata = '0, hrdata;
  logic [1:0]    htrans = 2'b00;
  logic [7:0]    irq_flags = '0, irq_enable = '0;
  swc_clk_src_e  osc_sel = SRC_FRC, clk_src_sel;
  swc_wake_act_e wake_action, last_act;
  int            miscompares = 0, n_tests = 0, cyc = 0;
  int            dly [5] = '{0, OSCILLATOR_STARTUP_TIMER, OSCILLATOR_STARTUP_TIMER + PLL, 0, OSCILLATOR_STARTUP_TIMER};

  always #4 clk = ~clk;

  swc_sleep_wake_controller #(.OST_N(OSCILLATOR_STARTUP_TIMER), .PLL_N(PLL), .REG_N(REG))
    u_swc_sleep_wake_controller (
    .CLK(clk), .RST_N(rst_n), .CE(1'b1), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata),
    .HREADY(hreadyout), .HREADYOUT(hreadyout), .HRESP(hresp),
    .HRDATA(hrdata), .SLEEP_REQ(sleep_req), .CFG_RETENTION_CONFIG_BIT(cfg_retention_config_bit),
    .DEEP_SLEEP_EN(deep_sleep_en), .OSC_SEL(osc_sel),
    .IRQ_FLAGS(irq_flags), .IRQ_ENABLE(irq_enable),
    .GLOBAL_IRQ_EN(global_irq_en), .RESET_REQ(reset_req),
    .WDT_EXPIRE(wdt_expire), .SOSC_RUNNING(sosc_running),
    .CORE_CLK_EN(core_clk_en), .MAIN_REG_EN(main_reg_en),
    .RET_REG_EN(ret_reg_en), .RAM_RETAIN(ram_retain),
    .CLK_SRC_SEL(clk_src_sel), .WAKE(wake), .WAKE_ACTION(wake_action),
    .IRQ(irq));

  swc_core_model u_swc_core_model (
    .clk(clk), .rst_n(rst_n), .go(go), .wake(wake),
    .wake_act(wake_action), .sleep_req(sleep_req), .last_act(last_act));

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic chk_rng(input int v, input int lo, input int hi,
                         input string msg);
    n_tests++;
    if (v < lo || v > hi) begin
      miscompares++;
      $display("wrong value at %0t: %s %0d", $time, msg, v);
    end
  endtask : chk_rng

  task automatic chk_irq(input logic exp, input string msg);
    @(negedge clk);
    chk(irq, exp, msg);
    @(posedge clk);
  endtask : chk_irq

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h00_0000, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] t;
    bus(1'b1, a, d, t);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus(1'b0, a, 32'h0000_0000, d);
  endtask : rd

  task automatic nap();
    int n;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    n = 0;
    // Sample settled outputs at the falling edge, then rejoin the rising one.
    do begin
      @(negedge clk);
      n++;
    end while (core_clk_en !== 1'b0 && n < 20);
    @(posedge clk);
  endtask : nap

  task automatic wake_by(input int k, output int lat);
    irq_flags <= (k == 0) ? 8'h01 : 8'h00;
    reset_req <= (k == 1);
    wdt_expire <= (k == 2);
    lat = 0;
    do begin
      @(negedge clk);
      lat++;
    end while (wake !== 1'b1 && lat < 100);
    @(posedge clk);
    irq_flags <= 8'h00;
    reset_req <= 1'b0;
    wdt_expire <= 1'b0;
  endtask : wake_by

  task automatic settle();
    logic [31:0] s;
    int n;
    n = 0;
    do begin
      rd(ADDR_STATE, s);
      n++;
    end while (s[1:0] !== 2'b00 && n < 50);
  endtask : settle

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic r;
    int lat, lp;
    lp = 0;
    repeat (7) @(posedge clk);
    @(negedge clk);
    chk({core_clk_en, main_reg_en, ret_reg_en, ram_retain}, 4'hC, "reset");
    @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h40, d);
    chk(d, 32'h0000_0000, "unmapped read");
    chk(hresp, 1'b0, "response");
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      cfg_retention_config_bit <= m[1];
      deep_sleep_en <= ~m[0];
      global_irq_en <= m[0];
      wr(ADDR_RESET_CONTROL_REG4, {27'h000_0000, m[0], 4'h0});
      irq_enable <= 8'h01;
      nap();
      r = !m[1] && m[0];
      chk({main_reg_en, ret_reg_en}, {!r, r}, "regulator");
      chk(ram_retain, r, "ram retention");
      irq_flags <= 8'h80;
      repeat (10) @(posedge clk);
      chk(core_clk_en, 1'b0, "clock held");
      wake_by(0, lat);
      if (r) chk_rng(lat, lp + REG, lp + REG + 8, "slow wake");
      else lp = lat;
      settle();
      chk(last_act, m[0] ? ACT_VECTOR : ACT_NEXT, "resume");
      chk({main_reg_en, ret_reg_en}, 2'b10, "regulator back");
    end
    rd(ADDR_RESET_CONTROL_REG4, d);
    chk(d, 32'h0000_0010, "software bit");
    $display("test modes done");
    for (int i = 0; i < 5; i++) begin
      osc_sel <= swc_clk_src_e'(i < 4 ? i : 3);
      sosc_running <= (i == 3);
      nap();
      wake_by(0, lat);
      chk(clk_src_sel, i < 4 ? i : 3, "same source");
      chk_rng(lat, dly[i] + 1, dly[i] + 8, "delay");
      settle();
    end
    $display("test sources done");
    wr(ADDR_CLKCFG, 32'h0000_0001);
    osc_sel <= SRC_XTAL_PLL;
    nap();
    wake_by(0, lat);
    chk(clk_src_sel, SRC_FRC, "fast rc first");
    chk_rng(lat, 1, OSCILLATOR_STARTUP_TIMER + PLL, "early clock");
    settle();
    chk(clk_src_sel, SRC_XTAL_PLL, "switched over");
    wr(ADDR_CLKCFG, 32'h0000_0000);
    $display("test two-speed done");
    rd(ADDR_STAT, d);
    wr(ADDR_MASK, 32'h0000_0000);
    nap();
    wake_by(1, lat);
    settle();
    chk(last_act, ACT_RESET, "reset wake");
    rd(ADDR_STAT, d);
    chk(d, 32'h0000_0009, "reset status");
    nap();
    wake_by(2, lat);
    settle();
    chk(last_act, ACT_NEXT, "watchdog resume");
    rd(ADDR_RESET_CONTROL_REG2, d);
    chk(d, 32'h0000_0020, "watchdog flag");
    wr(ADDR_RESET_CONTROL_REG2, 32'h0000_0000);
    rd(ADDR_RESET_CONTROL_REG2, d);
    chk(d, 32'h0000_0000, "flag cleared");
    chk_irq(1'b0, "masked");
    wr(ADDR_MASK, 32'h0000_0004);
    chk_irq(1'b1, "unmasked");
    rd(ADDR_STAT, d);
    chk(d, 32'h0000_0005, "watchdog status");
    chk_irq(1'b0, "read clears");
    $display("test wake sources done");
    give_verdict();
  end
endmodule : swc_sleep_wake_controller_bench
